// ==== design/high_side_switch_serial_control.sv ====
/*
 Digital control front end of a multi-channel high-side switch:
 16-bit daisy-chainable serial link, sleep/normal/fail modes, PWM,
 direct-input control, clock-pin feedback and sense synchronisation.
 Assumes every pin input is asynchronous to core_clk and that the
 serial clock stays well below a quarter of the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_serial_control #(
    parameter int WD_CYCLES = switch_ctrl_pkg::WD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reset_n_input,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic limp_home,
    input wire logic direct_input_1,
    input wire logic direct_input_2,
    input wire logic direct_input_3,
    input wire logic direct_input_4,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    output logic [4:0] channel_on,
    output logic external_switch_drive,
    output logic [2:0] analog_sense_source,
    output logic analog_sense_enable,
    output logic sense_sync_n_out,
    output logic sense_sync_n_oe,
    output logic fail_mode
);
    // ----------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------
    logic [9:0] pin_raw;
    logic [9:0] sync1_reg;
    logic [9:0] sync2_reg;
    logic [9:0] sync3_reg;
    logic [9:0] clean_reg;
    logic [9:0] clean_next;
    logic [9:0] prev_reg;

    assign pin_raw = {direct_input_4, direct_input_3, direct_input_2,
                      direct_input_1, clk_pin_in, limp_home, serial_in,
                      serial_clk, chip_select_n, reset_n_input};
    // A level is accepted only once the second and third stages agree
    assign clean_next = (sync2_reg & sync3_reg)
                      | (clean_reg & (sync2_reg ^ sync3_reg));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg <= switch_ctrl_pkg::PIN_RESET_VALUE;
            sync2_reg <= switch_ctrl_pkg::PIN_RESET_VALUE;
            sync3_reg <= switch_ctrl_pkg::PIN_RESET_VALUE;
            clean_reg <= switch_ctrl_pkg::PIN_RESET_VALUE;
            prev_reg <= switch_ctrl_pkg::PIN_RESET_VALUE;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            clean_reg <= clean_next;
            prev_reg <= clean_reg;
        end
    end

    wire dev_reset = ~clean_reg[switch_ctrl_pkg::PIN_RESET];
    wire cs_level = clean_reg[switch_ctrl_pkg::PIN_CS];
    wire cs_prev = prev_reg[switch_ctrl_pkg::PIN_CS];
    wire sclk_level = clean_reg[switch_ctrl_pkg::PIN_SCLK];
    wire sclk_prev = prev_reg[switch_ctrl_pkg::PIN_SCLK];
    wire ref_level = clean_reg[switch_ctrl_pkg::PIN_CLK];
    wire ref_prev = prev_reg[switch_ctrl_pkg::PIN_CLK];
    wire limp = clean_reg[switch_ctrl_pkg::PIN_LIMP];
    wire si_bit = clean_reg[switch_ctrl_pkg::PIN_SI];
    wire [3:0] inputs = clean_reg[switch_ctrl_pkg::PIN_IN_LSB +: 4];

    wire selected = ~cs_level;
    wire cs_fall = cs_prev & ~cs_level;
    wire cs_rise = ~cs_prev & cs_level;
    wire sclk_rise = selected & ~sclk_prev & sclk_level;
    wire sclk_fall = selected & sclk_prev & ~sclk_level;
    wire ref_rise = ref_prev & ~ref_level ? 1'b0 : ~ref_prev & ref_level;
    wire any_input = |inputs;

    // ----------------------------------------------------------
    // Serial shift path
    // ----------------------------------------------------------
    switch_ctrl_pkg::mode_type mode_reg;
    switch_ctrl_pkg::mode_type mode_next;
    logic [15:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic full_reg;
    logic so_reg;
    logic so_oe_reg;
    logic wd_fail_reg;
    logic [15:0] status_word;

    // Status is loaded at frame start so the host reads it back
    assign status_word = {7'h00, wd_fail_reg, limp, mode_reg, inputs};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shift_reg <= 16'h0000;
            bit_cnt_reg <= 4'h0;
            full_reg <= 1'b0;
        end else if (cs_fall) begin
            shift_reg <= status_word;
            bit_cnt_reg <= 4'h0;
            full_reg <= 1'b0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[14:0], si_bit};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == switch_ctrl_pkg::BIT_CNT_LAST) begin
                full_reg <= 1'b1;
            end
        end
    end

    // Chained devices clock 16*N bits; the last 16 are ours
    wire frame_done = cs_rise & full_reg
                    & (bit_cnt_reg == 4'h0) & ~dev_reset;
    wire [3:0] addr = shift_reg[switch_ctrl_pkg::ADDR_MSB:
                                switch_ctrl_pkg::ADDR_LSB];
    wire [11:0] data = shift_reg[11:0];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= selected;
            if (cs_fall) begin
                so_reg <= status_word[15];
            end else if (sclk_fall) begin
                so_reg <= shift_reg[15];
            end
        end
    end

    // ----------------------------------------------------------
    // Configuration writes
    // ----------------------------------------------------------
    switch_ctrl_pkg::ctrl_type ctrl_reg;
    switch_ctrl_pkg::sense_type sense_reg;
    switch_ctrl_pkg::chan_type chan_reg [0:4];

    wire wr_ctrl = frame_done & (addr == switch_ctrl_pkg::ADDR_CTRL);
    wire wr_sense = frame_done & (addr == switch_ctrl_pkg::ADDR_SENSE);
    wire enter_sleep = (mode_reg == switch_ctrl_pkg::MODE_NORMAL)
                     & (mode_next == switch_ctrl_pkg::MODE_SLEEP);

    always_ff @(posedge core_clk) begin
        if (!rst_n || dev_reset) begin
            ctrl_reg <= switch_ctrl_pkg::CTRL_RESET;
            sense_reg <= switch_ctrl_pkg::SENSE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= data[6:0];
            end else if (enter_sleep) begin
                ctrl_reg.go_sleep <= 1'b0;
            end
            if (wr_sense) begin
                sense_reg <= data[3:0];
            end
        end
    end

    // ----------------------------------------------------------
    // Mode control and host watchdog
    // ----------------------------------------------------------
    logic [23:0] wd_cnt_reg;
    wire wd_expired = wd_cnt_reg == 24'(WD_CYCLES - 1);

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            switch_ctrl_pkg::MODE_SLEEP: begin
                if (any_input || frame_done) begin
                    mode_next = limp ? switch_ctrl_pkg::MODE_FAIL
                                     : switch_ctrl_pkg::MODE_NORMAL;
                end
            end
            switch_ctrl_pkg::MODE_NORMAL: begin
                if (limp || wd_expired) begin
                    mode_next = switch_ctrl_pkg::MODE_FAIL;
                end else if (ctrl_reg.go_sleep && !any_input) begin
                    mode_next = switch_ctrl_pkg::MODE_SLEEP;
                end
            end
            switch_ctrl_pkg::MODE_FAIL: begin
                // Host must send a frame with limp released to recover
                if (!limp && frame_done) begin
                    mode_next = switch_ctrl_pkg::MODE_NORMAL;
                end
            end
            default: mode_next = switch_ctrl_pkg::MODE_SLEEP;
        endcase
        if (dev_reset) begin
            mode_next = switch_ctrl_pkg::MODE_SLEEP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg <= switch_ctrl_pkg::MODE_SLEEP;
            wd_cnt_reg <= 24'h000000;
            wd_fail_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (frame_done ||
                mode_reg != switch_ctrl_pkg::MODE_NORMAL) begin
                wd_cnt_reg <= 24'h000000;
            end else begin
                wd_cnt_reg <= wd_cnt_reg + 24'h000001;
            end
            // Set wins over the read-clear at frame start
            if (dev_reset) begin
                wd_fail_reg <= 1'b0;
            end else if (wd_expired &&
                         mode_reg == switch_ctrl_pkg::MODE_NORMAL) begin
                wd_fail_reg <= 1'b1;
            end else if (cs_fall) begin
                wd_fail_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // PWM timebase
    // ----------------------------------------------------------
    logic [7:0] ref_div_reg;
    logic [2:0] presc_cnt_reg;
    wire base_tick = ref_rise
                   & (ref_div_reg == switch_ctrl_pkg::REF_DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_div_reg <= 8'h00;
            presc_cnt_reg <= 3'h0;
        end else begin
            if (ref_rise) begin
                ref_div_reg <= ref_div_reg + 8'h01;
            end
            if (base_tick) begin
                presc_cnt_reg <= presc_cnt_reg + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------
    // Channels
    // ----------------------------------------------------------
    wire [4:0] in_wide = {1'b0, inputs};
    wire [4:0] den_wide = {1'b0, ctrl_reg.direct_en};
    logic [7:0] pwm_cnt_reg [0:4];
    logic [4:0] pwm_on;
    logic [4:0] chan_out_reg;
    logic [4:0] sync_hit;

    genvar i;
    generate
        for (i = 0; i < switch_ctrl_pkg::CHANNELS; i++) begin : g_chan
            wire wr_chan = frame_done
                & (addr == switch_ctrl_pkg::ADDR_CHAN_BASE + 4'(i));
            wire [2:0] mask = 3'((4'h1 << chan_reg[i].presc) - 4'h1);
            wire tick = base_tick
                & ((presc_cnt_reg & mask) == mask);
            wire normal_on = den_wide[i] ? in_wide[i]
                                         : pwm_on[i];
            assign pwm_on[i] = chan_reg[i].on
                & (pwm_cnt_reg[i] < chan_reg[i].duty);
            assign sync_hit[i] = pwm_on[i]
                & (pwm_cnt_reg[i] == {1'b0, chan_reg[i].duty[7:1]});

            always_ff @(posedge core_clk) begin
                if (!rst_n || dev_reset) begin
                    chan_reg[i] <= switch_ctrl_pkg::CHAN_RESET;
                    pwm_cnt_reg[i] <= 8'h00;
                    chan_out_reg[i] <= 1'b0;
                end else begin
                    if (wr_chan) begin
                        chan_reg[i] <= data[10:0];
                    end
                    if (tick) begin
                        pwm_cnt_reg[i] <= pwm_cnt_reg[i] + 8'h01;
                    end
                    case (mode_reg)
                        switch_ctrl_pkg::MODE_NORMAL:
                            chan_out_reg[i] <= normal_on;
                        switch_ctrl_pkg::MODE_FAIL:
                            chan_out_reg[i] <= in_wide[i];
                        default: chan_out_reg[i] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------
    logic clk_out_reg;
    logic clk_oe_reg;
    logic ext_reg;
    logic sync_low_reg;
    logic sync_out_reg;
    logic fail_reg;

    wire is_sleep = mode_reg == switch_ctrl_pkg::MODE_SLEEP;
    wire is_normal = mode_reg == switch_ctrl_pkg::MODE_NORMAL;
    wire src_is_chan = sense_reg.src < switch_ctrl_pkg::SRC_TEMP;
    wire src_is_env = (sense_reg.src == switch_ctrl_pkg::SRC_TEMP)
                    | (sense_reg.src == switch_ctrl_pkg::SRC_SUPPLY);
    // Channel source: pulse at mid on-time; temp and supply: hold asserted; source 7: never
    wire sync_want = sense_reg.en & ~is_sleep
        & (src_is_chan ? sync_hit[sense_reg.src] : src_is_env);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_out_reg <= 1'b0;
            clk_oe_reg <= 1'b1;
            ext_reg <= 1'b0;
            sync_low_reg <= 1'b0;
            sync_out_reg <= 1'b1;
            fail_reg <= 1'b0;
        end else begin
            // Sleep always owns the pin; awake it may take the ref
            clk_oe_reg <= ctrl_reg.clk_feedback | is_sleep;
            clk_out_reg <= ~is_sleep;
            // Lost host means no one commands the external switch
            ext_reg <= ctrl_reg.ext_on & is_normal;
            sync_low_reg <= sync_want;
            // Own flop keeps the pin level glitch free next to its enable
            sync_out_reg <= ~sync_want;
            fail_reg <= mode_reg == switch_ctrl_pkg::MODE_FAIL;
        end
    end

    assign serial_out = so_reg;
    assign serial_out_oe = so_oe_reg;
    assign clk_pin_out = clk_out_reg;
    assign clk_pin_oe = clk_oe_reg;
    assign channel_on = chan_out_reg;
    assign external_switch_drive = ext_reg;
    assign analog_sense_source = sense_reg.src;
    assign analog_sense_enable = sense_reg.en;
    assign sense_sync_n_out = sync_out_reg;
    assign sense_sync_n_oe = sync_low_reg;
    assign fail_mode = fail_reg;
endmodule
`default_nettype wire

// ==== pkg/switch_ctrl_pkg.sv ====
/*
 Constants, field layouts and carrier types for the serial control
 front end of a multi-channel high-side switch.
 Assumes a single 40 MHz core clock shared by every user of it.
*/
`default_nettype none
package switch_ctrl_pkg;
    // ----------------------------------------------------------
    // Timing
    // ----------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int SPI_MAX_HZ = 5_000_000;
    localparam int WD_TIMEOUT_US = 10_000;
    localparam int WD_CYCLES = WD_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int WD_BITS = 24;
    // ----------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam logic [3:0] BIT_CNT_LAST = 4'hf;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 12;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_CHAN_BASE = 4'h2;
    localparam logic [3:0] ADDR_SENSE = 4'h7;
    // Control word fields
    localparam int DIRECT_EN_LSB = 0;
    localparam int EXT_ON_BIT = 4;
    localparam int FEEDBACK_BIT = 5;
    localparam int GO_SLEEP_BIT = 6;
    // Channel word fields
    localparam int DUTY_LSB = 0;
    localparam int PRESC_LSB = 8;
    localparam int CHAN_ON_BIT = 10;
    // Sense word fields and source codes
    localparam int SRC_LSB = 0;
    localparam int SENSE_EN_BIT = 3;
    localparam logic [2:0] SRC_TEMP = 3'h5;
    localparam logic [2:0] SRC_SUPPLY = 3'h6;
    // ----------------------------------------------------------
    // Channels, PWM and pin sampling
    // ----------------------------------------------------------
    localparam int CHANNELS = 5;
    localparam int DIRECT_INPUTS = 4;
    localparam logic [7:0] REF_DIV_LAST = 8'hff;
    localparam int PIN_COUNT = 10;
    localparam int PIN_RESET = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SI = 3;
    localparam int PIN_LIMP = 4;
    localparam int PIN_CLK = 5;
    localparam int PIN_IN_LSB = 6;
    localparam logic [9:0] PIN_RESET_VALUE = 10'h002;

    typedef enum logic [2:0] {
        MODE_SLEEP = 3'b001,
        MODE_NORMAL = 3'b010,
        MODE_FAIL = 3'b100
    } mode_type;

    typedef struct packed {
        logic go_sleep;
        logic clk_feedback;
        logic ext_on;
        logic [3:0] direct_en;
    } ctrl_type;

    typedef struct packed {
        logic on;
        logic [1:0] presc;
        logic [7:0] duty;
    } chan_type;

    typedef struct packed {
        logic en;
        logic [2:0] src;
    } sense_type;

    localparam ctrl_type CTRL_RESET = 7'h20;
    localparam chan_type CHAN_RESET = 11'h000;
    localparam sense_type SENSE_RESET = 4'h0;
endpackage
`default_nettype wire

// ==== tb/hss_checker_asserts.sv ====
/*
 Concurrent checks on the pins of the switch serial control front end.
 Assumes it is bound into the design and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module hss_checker_asserts #(
    parameter int WD_CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reset_n_input,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic limp_home,
    input wire logic direct_input_1,
    input wire logic direct_input_2,
    input wire logic direct_input_3,
    input wire logic direct_input_4,
    input wire logic clk_pin_in,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    input wire logic [4:0] channel_on,
    input wire logic external_switch_drive,
    input wire logic [2:0] analog_sense_source,
    input wire logic analog_sense_enable,
    input wire logic sense_sync_n_out,
    input wire logic sense_sync_n_oe,
    input wire logic fail_mode
);
    // ----------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------
    int cs_hi_cnt;
    int idle_cnt;
    wire logic [3:0] dir_in = {direct_input_4, direct_input_3,
        direct_input_2, direct_input_1};
    always_ff @(posedge core_clk)
        if (!rst_n || !chip_select_n) cs_hi_cnt <= 0;
        else if (cs_hi_cnt < 1000) cs_hi_cnt <= cs_hi_cnt + 1;
    // Margin of 20 covers commit latency after the select edge
    always_ff @(posedge core_clk)
        if (!rst_n || !chip_select_n || !clk_pin_out) idle_cnt <= 0;
        else if (idle_cnt <= WD_CYCLES + 20) idle_cnt <= idle_cnt + 1;
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fail_steady;
        (fail_mode && $stable(dir_in))[*6];
    endsequence
    sequence s_limp_held;
        (limp_home && reset_n_input)[*8] ##0 (clk_pin_out || fail_mode);
    endsequence
    a_oe_cs_high: assert property (
        chip_select_n[*8] |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    a_oe_follow: assert property (
        $fell(chip_select_n) && reset_n_input |-> ##[3:6] serial_out_oe)
        else $error("serial out not driven after select");
    a_so_on_fall: assert property (
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> !$past(serial_clk) && !$past(serial_clk, 3))
        else $error("serial out moved away from a falling clock");
    a_sync_open_drain: assert property (
        sense_sync_n_oe |-> !sense_sync_n_out)
        else $error("sync pin driven high");
    a_fail_follow: assert property (
        s_fail_steady |-> channel_on == {1'b0, dir_in}
        && !external_switch_drive)
        else $error("channels do not follow inputs in fail mode");
    a_limp_fail: assert property (s_limp_held |-> fail_mode)
        else $error("limp input did not force fail mode");
    a_wd_fail: assert property (
        idle_cnt == WD_CYCLES + 20 |-> fail_mode)
        else $error("lost host frames did not force fail mode");
    a_ext_by_frame: assert property (
        $rose(external_switch_drive) |-> cs_hi_cnt <= 12)
        else $error("external switch moved without a frame");
    a_sleep_drive: assert property (
        (!clk_pin_out)[*2] |-> clk_pin_oe)
        else $error("clock pin not driven in sleep");
    a_reset_sleep: assert property (
        (!reset_n_input)[*8] |-> !clk_pin_out && !fail_mode
        && channel_on == 5'h00 && !external_switch_drive)
        else $error("reset pin did not clear and sleep");
endmodule
bind high_side_switch_serial_control hss_checker_asserts #(
    .WD_CYCLES(WD_CYCLES)
) chk (
    .core_clk, .rst_n, .reset_n_input, .chip_select_n, .serial_clk,
    .serial_in, .serial_out, .serial_out_oe, .limp_home,
    .direct_input_1, .direct_input_2, .direct_input_3, .direct_input_4,
    .clk_pin_in, .clk_pin_out, .clk_pin_oe, .channel_on,
    .external_switch_drive, .analog_sense_source, .analog_sense_enable,
    .sense_sync_n_out, .sense_sync_n_oe, .fail_mode
);
`default_nettype wire

// ==== tb/host_model.sv ====
/*
 Behavioural host that masters the 16-bit serial link.
 Assumes the caller enters its tasks just after a core clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic serial_out,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_in
);
    localparam int HALF = 8; // 200 ns half period, 2.5 MHz
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // Deselected data line toggles so no stale bit looks valid
    always @(posedge core_clk)
        if (chip_select_n) serial_in <= ~serial_in;
    task automatic word(input logic [15:0] tx, input bit first,
        input bit last, output logic [15:0] rx);
        if (first) begin
            chip_select_n <= 1'b0;
            repeat (HALF) @(posedge core_clk);
        end
        for (int i = 15; i >= 0; i--) begin
            serial_in <= tx[i]; // MSB first, 16 per unit
            repeat (HALF) @(posedge core_clk);
            serial_clk <= 1'b1;
            rx[i] = serial_out;
            repeat (HALF) @(posedge core_clk);
            serial_clk <= 1'b0;
        end
        if (last) begin
            repeat (HALF) @(posedge core_clk);
            chip_select_n <= 1'b1;
            repeat (HALF) @(posedge core_clk);
        end
    endtask
    // Clock activity with the device deselected
    task automatic noise(input int n);
        repeat (n) begin
            serial_clk <= ~serial_clk;
            repeat (HALF) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for the switch serial control front end.
 Assumes the host model on the link and ref_clk on the released clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int WD = 4000;
    // Rows: frame, direct input 1, then ext, channels, source, en, sync
    localparam logic [27:0] ROWS [10] = '{
        28'h1030400, 28'h24ff420, 28'h6480620, 28'h700d637, 28'h700e63b,
        28'h7002628, 28'h8fff628, 28'h1021208, 28'h1021a28, 28'h1020228};
    logic core_clk, rst_n, reset_n_input, limp_home, ref_clk;
    logic direct_input_1, direct_input_2, direct_input_3, direct_input_4;
    logic chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
    logic clk_pin_out, clk_pin_oe, external_switch_drive, fail_mode;
    logic analog_sense_enable, sense_sync_n_out, sense_sync_n_oe;
    logic [4:0] channel_on;
    logic [2:0] analog_sense_source;
    logic [15:0] rx;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    wire logic clk_pin_in = clk_pin_oe ? clk_pin_out : ref_clk;
    wire logic [10:0] obs = {external_switch_drive, channel_on,
        analog_sense_source, analog_sense_enable, sense_sync_n_oe};
    high_side_switch_serial_control #(.WD_CYCLES(WD)) dut (
        .core_clk, .rst_n, .reset_n_input, .chip_select_n, .serial_clk,
        .serial_in, .serial_out, .serial_out_oe, .limp_home,
        .direct_input_1, .direct_input_2, .direct_input_3, .direct_input_4,
        .clk_pin_in, .clk_pin_out, .clk_pin_oe, .channel_on,
        .external_switch_drive, .analog_sense_source, .analog_sense_enable,
        .sense_sync_n_out, .sense_sync_n_oe, .fail_mode);
    host_model host (.core_clk, .serial_out, .chip_select_n, .serial_clk,
        .serial_in);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic frame(input logic [15:0] tx);
        host.word(tx, 1'b1, 1'b1, rx);
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        conclude();
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {rst_n, limp_home, ref_clk, reset_n_input} = 4'h1;
        {direct_input_4, direct_input_3, direct_input_2} = 3'h0;
        direct_input_1 = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        check(16'({clk_pin_oe, clk_pin_out, fail_mode, serial_out_oe,
            external_switch_drive, channel_on}), 16'h200);
        host.noise(6);
        frame(16'h1030);
        check(rx, 16'h0010);
        check(16'(clk_pin_out), 16'h1);
        foreach (ROWS[i]) begin
            direct_input_1 <= ROWS[i][11];
            frame(ROWS[i][27:12]);
            check(16'(obs), 16'(ROWS[i][10:0]));
        end
        direct_input_1 <= 1'b0;
        repeat (8) @(posedge core_clk);
        host.word(16'habcd, 1'b1, 1'b0, rx);
        check(rx, 16'h0020);
        host.word(16'h0000, 1'b0, 1'b1, rx);
        check(rx, 16'habcd);
        // Pin released to the reference; one channel step per 256 edges
        frame(16'h1000);
        frame(16'h2401);
        n = 0;
        while (channel_on[0] === 1'b1 && n < 300) begin
            ref_clk <= 1'b1;
            repeat (5) @(posedge core_clk);
            ref_clk <= 1'b0;
            repeat (5) @(posedge core_clk);
            n++;
        end
        check(16'(n >= 255 && n <= 257), 16'h1);
        frame(16'h1030);
        {direct_input_4, direct_input_2, limp_home} <= 3'h7;
        repeat (10) @(posedge core_clk);
        check(16'({fail_mode, external_switch_drive, channel_on}),
            16'h4a);
        {direct_input_4, direct_input_2, limp_home} <= 3'h0;
        repeat (10) @(posedge core_clk);
        check(16'(fail_mode), 16'h1);
        frame(16'h0000);
        check(rx, 16'h0040);
        check(16'(fail_mode), 16'h0);
        n = 0;
        while (fail_mode !== 1'b1 && n < WD + 100) begin
            @(posedge core_clk);
            n++;
        end
        check(16'(n > WD - 30 && n < WD + 30), 16'h1);
        if (n == WD + 100) conclude();
        frame(16'h0000);
        check(rx, 16'h0140);
        frame(16'h1060);
        repeat (4) @(posedge core_clk);
        check(16'({clk_pin_oe, clk_pin_out}), 16'h2);
        direct_input_3 <= 1'b1;
        repeat (10) @(posedge core_clk);
        check(16'({clk_pin_out, fail_mode}), 16'h2);
        direct_input_3 <= 1'b0;
        frame(16'h1030);
        reset_n_input <= 1'b0;
        repeat (10) @(posedge core_clk);
        frame(16'h1030);
        check(16'({external_switch_drive, clk_pin_out, channel_on}),
            16'h0);
        reset_n_input <= 1'b1;
        repeat (10) @(posedge core_clk);
        frame(16'h0000);
        check(rx, 16'h0010);
        conclude();
    end
endmodule
`default_nettype wire
